// ---- nand_host_pkg.sv ----
// constants, types and register map of the nand flash host controller
// assumes a 40 MHz core clock; all times below turn into cycles of it
package nand_host_pkg;

   // =======================================================
   // software register map (byte offsets, 32-bit words)
   localparam logic [4:0] OFS_CMD    = 5'h00;  // write: one command cycle
   localparam logic [4:0] OFS_ADDR   = 5'h04;  // write: address burst, kind in [1:0]
   localparam logic [4:0] OFS_COL    = 5'h08;  // column index
   localparam logic [4:0] OFS_ROW    = 5'h0C;  // row address
   localparam logic [4:0] OFS_DATA   = 5'h10;  // write: data input cycle, read: last fetched byte
   localparam logic [4:0] OFS_STATUS = 5'h14;  // read: status, write: clear refused flag
   localparam logic [4:0] OFS_CTRL   = 5'h18;  // chip select enable, write protect release
   localparam logic [4:0] OFS_FETCH  = 5'h1C;  // write: one serial output cycle

   // status and control bit positions
   localparam int unsigned ST_BUSY    = 0;
   localparam int unsigned ST_READY   = 1;
   localparam int unsigned ST_REFUSED = 2;
   localparam int unsigned CT_CS      = 0;
   localparam int unsigned CT_WP      = 1;
   localparam logic [1:0]  CTRL_RST   = 2'h0;  // deselected and write protected

   // address burst kinds
   localparam logic [1:0] ADDR_COL  = 2'h0;   // cycles 1..2
   localparam logic [1:0] ADDR_ROW  = 2'h1;   // cycles 3..5
   localparam logic [1:0] ADDR_FULL = 2'h2;   // cycles 1..5

   // =======================================================
   // array geometry
   localparam int unsigned PAGE_MAIN       = 4096;
   localparam int unsigned PAGE_SPARE      = 128;
   localparam int unsigned PAGE_BYTES      = PAGE_MAIN + PAGE_SPARE;
   localparam int unsigned PAGES_PER_BLOCK = 64;
   localparam int unsigned BLOCKS          = 2048;
   localparam int unsigned COL_W           = 13;
   localparam int unsigned ROW_W           = 17;
   localparam int unsigned PAGE_W          = 6;

   // =======================================================
   // command codes
   localparam logic [7:0] CMD_READ      = 8'h00;
   localparam logic [7:0] CMD_READ_GO   = 8'h30;
   localparam logic [7:0] CMD_COPY_GO   = 8'h35;
   localparam logic [7:0] CMD_OCOL      = 8'h05;
   localparam logic [7:0] CMD_OCOL_GO   = 8'hE0;
   localparam logic [7:0] CMD_ICOL      = 8'h85;
   localparam logic [7:0] CMD_PROG      = 8'h80;
   localparam logic [7:0] CMD_PROG_GO   = 8'h10;
   localparam logic [7:0] CMD_MULTI_MID = 8'h11;
   localparam logic [7:0] CMD_MULTI_NXT = 8'h81;
   localparam logic [7:0] CMD_ERASE     = 8'h60;
   localparam logic [7:0] CMD_ERASE_GO  = 8'hD0;
   localparam logic [7:0] CMD_IDENT     = 8'h90;
   localparam logic [7:0] CMD_STAT      = 8'h70;
   localparam logic [7:0] CMD_MSTAT     = 8'h71;
   localparam logic [7:0] CMD_ECCSTAT   = 8'h7A;
   localparam logic [7:0] CMD_RESET     = 8'hFF;

   // =======================================================
   // timing, least times rounded up to whole cycles
   localparam int unsigned CLK_NS     = 25;
   localparam int unsigned T_WP_NS    = 12;
   localparam int unsigned T_WH_NS    = 10;
   localparam int unsigned T_REA_NS   = 20;
   localparam int unsigned T_WB_NS    = 100;
   localparam int unsigned SYNC_STAGES = 3;
   localparam int unsigned WP_CYC  = (T_WP_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned WH_CYC  = (T_WH_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned REA_CYC = (T_REA_NS + CLK_NS - 1) / CLK_NS;
   localparam int unsigned WB_CYC  = (T_WB_NS + CLK_NS - 1) / CLK_NS;
   // read strobe stays low until the byte has crossed the synchroniser and its agreement stage
   localparam int unsigned RLOW_CYC = REA_CYC + SYNC_STAGES + 1;

   // =======================================================
   // pin bundle and sequencer states
   typedef struct packed {
      logic cle;
      logic ale;
      logic ce_n;
      logic we_n;
      logic re_n;
      logic wp_n;
   } nand_pins_t;
   localparam nand_pins_t PINS_RST = '{cle: 1'b0, ale: 1'b0, ce_n: 1'b1,
                                       we_n: 1'b1, re_n: 1'b1, wp_n: 1'b0};

   typedef enum logic [1:0] {
      KIND_CMD  = 2'h0,
      KIND_ADDR = 2'h1,
      KIND_DIN  = 2'h2,
      KIND_DOUT = 2'h3
   } cyc_kind_t;

   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_LOW  = 3'b001,
      S_HIGH = 3'b011,
      S_GAP  = 3'b010
   } seq_state_t;

endpackage

// ---- pin_sync.sv ----
// three-stage synchroniser with agreement filter for pin inputs
// assumes inputs are asynchronous to core_clk; output moves when stages 2 and 3 agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int unsigned WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   // clock and reset
   input  wire logic             core_clk,
   input  wire logic             rst,
   // pins and filtered result
   input  wire logic [WIDTH-1:0] din,
   output var  logic [WIDTH-1:0] dout
);

   // =======================================================
   // per-bit chain
   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         logic s1;
         logic s2;
         logic s3;
         // s1 feeds only s2, never any logic
         always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
               s1 <= INIT[i];
               s2 <= INIT[i];
               s3 <= INIT[i];
            end else begin
               s1 <= din[i];
               s2 <= s1;
               s3 <= s2;
            end
         end
         // a change counts only once two stages agree, so one glitchy sample is dropped
         always_ff @(posedge core_clk or posedge rst) begin
            if (rst) begin
               dout[i] <= INIT[i];
            end else if (s2 == s3) begin
               dout[i] <= s3;
            end
         end
      end
   endgenerate

endmodule
`default_nettype wire

// ---- nand_host.sv ----
// host-side sequencer that drives an 8-bit nand flash through its pins
// assumes a plain register port from software and an external pull-up on op_done_flag
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - full address is five address cycles, two column then three row
// - cycle one column bits 7-0, cycle two bits 12-8, top three low
// - cycles three to five carry row bits, fifth only bit 16
// - command and address cycles use the documented latch and strobe levels
// - data input needs write protect high; serial output keeps write strobe high
// - while busy with chip selected, strobes stay high except status or reset
module nand_host (
   // clock and reset
   input  wire logic                    core_clk,
   input  wire logic                    rst,
   // software register port
   input  wire logic [4:0]              reg_addr,
   input  wire logic [31:0]             reg_wdata,
   input  wire logic                    reg_wr,
   input  wire logic                    reg_rd,
   output var  logic [31:0]             reg_rdata,
   // flash control pins
   output var  nand_host_pkg::nand_pins_t pins,
   // shared data bus, three signals
   output var  logic [7:0]              io_out,
   output var  logic                    io_oe_n,
   input  wire logic [7:0]              io_in,
   // ready line from the flash
   input  wire logic                    op_done_flag
);

   // =======================================================
   // state
   nand_host_pkg::seq_state_t state;
   nand_host_pkg::cyc_kind_t  kind;
   logic [7:0]  cnt;
   logic [2:0]  idx;
   logic [2:0]  idx_last;
   logic [1:0]  addr_mode;
   logic [12:0] col;
   logic [16:0] row;
   logic [7:0]  rx_byte;
   logic        cs_en;
   logic        wp_rel;
   logic        refused;
   logic        dev_ready;
   logic [7:0]  io_sync;

   // pins from outside the clock domain
   pin_sync #(.WIDTH(9), .INIT(9'h100)) u_sync (
      .core_clk (core_clk),
      .rst      (rst),
      .din      ({op_done_flag, io_in}),
      .dout     ({dev_ready, io_sync})
   );

   // =======================================================
   // request decode
   function automatic logic [7:0] addr_byte(input logic [2:0] i, input logic [12:0] c,
                                            input logic [16:0] r);
      case (i)
         3'h0:    addr_byte = c[7:0];
         3'h1:    addr_byte = {3'h0, c[12:8]};
         3'h2:    addr_byte = r[7:0];
         3'h3:    addr_byte = r[15:8];
         default: addr_byte = {7'h00, r[16]};
      endcase
   endfunction

   logic       idle;
   logic       is_cmd;
   logic       is_addr;
   logic       is_din;
   logic       is_dout;
   logic       busy_ok;
   logic       col_ok;
   logic       go;
   logic       bad;
   logic [2:0] first_idx;
   logic [2:0] last_idx;

   // legality of each software order against device and pin state
   always_comb begin
      idle      = (state == nand_host_pkg::S_IDLE);
      is_cmd    = reg_wr && (reg_addr == nand_host_pkg::OFS_CMD);
      is_addr   = reg_wr && (reg_addr == nand_host_pkg::OFS_ADDR);
      is_din    = reg_wr && (reg_addr == nand_host_pkg::OFS_DATA);
      is_dout   = reg_wr && (reg_addr == nand_host_pkg::OFS_FETCH);
      busy_ok   = (reg_wdata[7:0] == nand_host_pkg::CMD_STAT) ||
                  (reg_wdata[7:0] == nand_host_pkg::CMD_MSTAT) ||
                  (reg_wdata[7:0] == nand_host_pkg::CMD_RESET);
      col_ok    = (reg_wdata[1:0] == nand_host_pkg::ADDR_ROW) ||
                  ({19'h0, col} < nand_host_pkg::PAGE_BYTES);
      first_idx = (reg_wdata[1:0] == nand_host_pkg::ADDR_ROW) ? 3'h2 : 3'h0;
      last_idx  = (reg_wdata[1:0] == nand_host_pkg::ADDR_COL) ? 3'h1 : 3'h4;
      go        = 1'b0;
      if (idle && cs_en && !pins.ce_n) begin
         // busy with chip selected: only the short list may strobe
         go = (is_cmd && (dev_ready || busy_ok)) ||
              (is_addr && dev_ready && col_ok && (reg_wdata[1:0] != 2'h3)) ||
              (is_din && dev_ready && wp_rel) ||
              (is_dout && dev_ready);
      end
      bad = (is_cmd || is_addr || is_din || is_dout) && !go;
   end

   // =======================================================
   // software-held registers
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         col    <= '0;
         row    <= '0;
         cs_en  <= nand_host_pkg::CTRL_RST[nand_host_pkg::CT_CS];
         wp_rel <= nand_host_pkg::CTRL_RST[nand_host_pkg::CT_WP];
      end else if (reg_wr) begin
         if (reg_addr == nand_host_pkg::OFS_COL) begin
            col <= reg_wdata[12:0];
         end
         if (reg_addr == nand_host_pkg::OFS_ROW) begin
            row <= reg_wdata[16:0];   // page in [5:0], block in [16:6]
         end
         if (reg_addr == nand_host_pkg::OFS_CTRL) begin
            cs_en  <= reg_wdata[nand_host_pkg::CT_CS];
            wp_rel <= reg_wdata[nand_host_pkg::CT_WP];
         end
      end
   end

   // refused flag: a new refusal wins over a clear in the same cycle
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         refused <= 1'b0;
      end else if (bad) begin
         refused <= 1'b1;
      end else if (reg_wr && (reg_addr == nand_host_pkg::OFS_STATUS)) begin
         refused <= 1'b0;
      end
   end

   // read port, data one cycle after the strobe
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= '0;
      end else if (reg_rd) begin
         case (reg_addr)
            nand_host_pkg::OFS_COL:    reg_rdata <= {19'h0, col};
            nand_host_pkg::OFS_ROW:    reg_rdata <= {15'h0, row};
            nand_host_pkg::OFS_DATA:   reg_rdata <= {24'h0, rx_byte};
            nand_host_pkg::OFS_STATUS: reg_rdata <= {29'h0, refused, dev_ready, !idle};
            nand_host_pkg::OFS_CTRL:   reg_rdata <= {30'h0, wp_rel, cs_en};
            default:                   reg_rdata <= '0;
         endcase
      end
   end

   // =======================================================
   // pin sequencer: strobe low phase, strobe high phase, settle gap
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state     <= nand_host_pkg::S_IDLE;
         kind      <= nand_host_pkg::KIND_CMD;
         cnt       <= '0;
         idx       <= '0;
         idx_last  <= '0;
         addr_mode <= '0;
         rx_byte   <= '0;
         io_out    <= '0;
         io_oe_n   <= 1'b1;
         pins      <= nand_host_pkg::PINS_RST;
      end else begin
         pins.wp_n <= wp_rel;
         case (state)
            nand_host_pkg::S_IDLE: begin
               // chip select only moves between cycles, never under a strobe
               pins.ce_n <= !cs_en;
               if (go) begin
                  cnt <= 8'(nand_host_pkg::WP_CYC - 1);
                  idx <= first_idx;
                  idx_last  <= last_idx;
                  addr_mode <= reg_wdata[1:0];
                  state <= nand_host_pkg::S_LOW;
                  if (is_dout) begin
                     kind      <= nand_host_pkg::KIND_DOUT;
                     cnt       <= 8'(nand_host_pkg::RLOW_CYC - 1);
                     pins.re_n <= 1'b0;
                  end else begin
                     pins.we_n <= 1'b0;
                     io_oe_n   <= 1'b0;
                     if (is_cmd) begin
                        kind     <= nand_host_pkg::KIND_CMD;
                        pins.cle <= 1'b1;
                        io_out   <= reg_wdata[7:0];
                     end else if (is_addr) begin
                        kind     <= nand_host_pkg::KIND_ADDR;
                        pins.ale <= 1'b1;
                        io_out   <= addr_byte(first_idx, col, row);
                     end else begin
                        kind   <= nand_host_pkg::KIND_DIN;
                        io_out <= reg_wdata[7:0];
                     end
                  end
               end
            end
            nand_host_pkg::S_LOW: begin
               if (cnt != 8'h00) begin
                  cnt <= cnt - 8'h01;
               end else begin
                  // rising strobe edge is where the flash latches
                  pins.we_n <= 1'b1;
                  if (kind == nand_host_pkg::KIND_DOUT) begin
                     rx_byte   <= io_sync;
                     pins.re_n <= 1'b1;
                  end
                  cnt   <= 8'(nand_host_pkg::WH_CYC - 1);
                  state <= nand_host_pkg::S_HIGH;
               end
            end
            nand_host_pkg::S_HIGH: begin
               if (cnt != 8'h00) begin
                  cnt <= cnt - 8'h01;
               end else if (kind == nand_host_pkg::KIND_ADDR && idx != idx_last) begin
                  // next address byte, latch stays high across the burst
                  idx       <= idx + 3'h1;
                  io_out    <= addr_byte(idx + 3'h1, col, row);
                  pins.we_n <= 1'b0;
                  cnt       <= 8'(nand_host_pkg::WP_CYC - 1);
                  state     <= nand_host_pkg::S_LOW;
               end else begin
                  pins.cle <= 1'b0;
                  pins.ale <= 1'b0;
                  io_oe_n  <= 1'b1;
                  // after a command the ready line is not valid until the busy delay
                  cnt   <= 8'(nand_host_pkg::WB_CYC + nand_host_pkg::SYNC_STAGES - 1);
                  state <= (kind == nand_host_pkg::KIND_CMD) ? nand_host_pkg::S_GAP
                                                             : nand_host_pkg::S_IDLE;
               end
            end
            nand_host_pkg::S_GAP: begin
               if (cnt != 8'h00) begin
                  cnt <= cnt - 8'h01;
               end else begin
                  state <= nand_host_pkg::S_IDLE;
               end
            end
            default: begin
               state <= nand_host_pkg::S_IDLE;
            end
         endcase
      end
   end

   // =======================================================
   // checks
   logic [2:0] ale_edges;
   // counts write strobe rises inside one address burst
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ale_edges <= '0;
      end else if (!pins.ale) begin
         ale_edges <= '0;
      end else if (pins.we_n && !$past(pins.we_n)) begin
         ale_edges <= ale_edges + 3'h1;
      end
   end

   cmd_latch_a: assert property (@(posedge core_clk) disable iff (rst)
      ($rose(pins.we_n) && pins.cle) |-> (!pins.ale && !pins.ce_n && pins.re_n && !io_oe_n))
      else $error("command latched with wrong pin levels");
   addr_latch_a: assert property (@(posedge core_clk) disable iff (rst)
      ($rose(pins.we_n) && pins.ale) |-> (!pins.cle && !pins.ce_n && pins.re_n && !io_oe_n))
      else $error("address latched with wrong pin levels");
   addr_count_a: assert property (@(posedge core_clk) disable iff (rst)
      $fell(pins.ale) |-> (ale_edges == ((addr_mode == nand_host_pkg::ADDR_COL) ? 3'd2 :
                           (addr_mode == nand_host_pkg::ADDR_ROW) ? 3'd3 : 3'd5)))
      else $error("address burst has wrong cycle count");
   addr_col_hi_a: assert property (@(posedge core_clk) disable iff (rst)
      ($rose(pins.we_n) && pins.ale && idx == 3'h1) |-> (io_out[7:5] == 3'h0 && io_out[4:0] == col[12:8]))
      else $error("second address byte malformed");
   addr_row_hi_a: assert property (@(posedge core_clk) disable iff (rst)
      ($rose(pins.we_n) && pins.ale && idx == 3'h4) |-> (io_out == {7'h00, row[16]}))
      else $error("fifth address byte malformed");
   din_protect_a: assert property (@(posedge core_clk) disable iff (rst)
      ($rose(pins.we_n) && !pins.cle && !pins.ale) |-> pins.wp_n)
      else $error("data input while write protected");
   dout_levels_a: assert property (@(posedge core_clk) disable iff (rst)
      $fell(pins.re_n) |-> (!pins.re_n && pins.we_n && !pins.cle && !pins.ale && io_oe_n)[*5]
      ##1 pins.re_n)
      else $error("serial output strobe malformed");
   busy_strobe_a: assert property (@(posedge core_clk) disable iff (rst)
      ($fell(pins.we_n) && !$past(dev_ready)) |-> (pins.cle &&
      (io_out == nand_host_pkg::CMD_STAT || io_out == nand_host_pkg::CMD_MSTAT ||
       io_out == nand_host_pkg::CMD_RESET)))
      else $error("strobe while device busy");
   standby_a: assert property (@(posedge core_clk) disable iff (rst)
      (idle && !cs_en) |=> pins.ce_n)
      else $error("chip select not released when idle");

   cmd_seen_c:  cover property (@(posedge core_clk) disable iff (rst) $rose(pins.we_n) && pins.cle);
   full_addr_c: cover property (@(posedge core_clk) disable iff (rst) $fell(pins.ale) && ale_edges == 3'd5);
   fetch_c:     cover property (@(posedge core_clk) disable iff (rst) $rose(pins.re_n));
   refuse_c:    cover property (@(posedge core_clk) disable iff (rst) bad);

endmodule
`default_nettype wire

// ---- flash_model.sv ----
// behavioural 8-bit nand flash standing at the far side of nand_host
// assumes tb resolves the shared bus and supplies the pull-up on the ready line
`timescale 1ns/1ps
`default_nettype none
module flash_model (
   // pins from the host
   input  wire nand_host_pkg::nand_pins_t pins,
   input  wire logic [7:0]                bus,
   // data output and open-drain ready line
   output var  logic [7:0]                dout,
   output var  logic                      drive,
   output var  logic                      busy_pull,
   // observed traffic
   output var  logic [7:0]                last_cmd,
   output var  logic [39:0]               addr_bytes,
   output var  logic                      standby
);
   logic [12:0] col = 13'h0000;
   logic [2:0]  n = 3'h0;
   event        go;
   initial begin
      dout = 8'h00;
      busy_pull = 1'b0;
      last_cmd = 8'h00;
      addr_bytes = 40'h0;
   end
   // latch on strobe rise; while busy only status and reset get in
   always @(posedge pins.we_n) begin
      if (!pins.ce_n && pins.cle && (!busy_pull || bus inside {8'h70, 8'h71, 8'hFF})) begin
         last_cmd = bus;
         n = 3'h0;
         if (bus inside {8'h30, 8'h35} || (pins.wp_n && bus inside {8'h10, 8'hD0})) ->go;
      end else if (!pins.ce_n && pins.ale && !busy_pull && n < 3'h5) begin
         addr_bytes[8*n +: 8] = bus;
         if (n == 3'h0) col[7:0] = bus;
         if (n == 3'h1) col[12:8] = bus[4:0];
         n = n + 3'h1;
      end
   end
   // sinks the ready line for a fixed, short operation time
   always @(go) begin
      busy_pull = 1'b1;
      #1000;
      busy_pull = 1'b0;
   end
   // byte presented on strobe fall, column counter steps after it
   always @(negedge pins.re_n) begin
      dout = col[7:0] ^ 8'h5A;
      col = col + 13'h0001;
   end
   always_comb begin
      drive = !pins.ce_n && !pins.re_n && !pins.cle && !pins.ale && pins.we_n;
      standby = pins.ce_n && !busy_pull;
   end
endmodule
`default_nettype wire

// ---- tb.sv ----
// register-level testbench for nand_host against flash_model
// assumes a 40 MHz clock and the register map of nand_host_pkg
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic                      core_clk = 1'b0;
   logic                      rst = 1'b1;
   logic [4:0]                reg_addr = 5'h00;
   logic [31:0]               reg_wdata = 32'h0;
   logic                      reg_wr = 1'b0;
   logic                      reg_rd = 1'b0;
   logic [31:0]               reg_rdata;
   logic [31:0]               v;
   logic [7:0]                io_out;
   logic [7:0]                m_dout;
   logic [7:0]                last_cmd;
   logic [7:0]                float_v = 8'h3C;
   logic                      io_oe_n;
   logic                      m_drive;
   logic                      busy_pull;
   logic                      standby;
   logic [39:0]               addr_bytes;
   nand_host_pkg::nand_pins_t pins;
   int                        mismatches = 0;
   int                        cmp_count = 0;
   localparam logic [7:0] CODES [17] = '{8'h00, 8'h30, 8'h35, 8'h05, 8'hE0, 8'h85, 8'h80, 8'h10, 8'h11,
                                         8'h81, 8'h60, 8'hD0, 8'h90, 8'h70, 8'h71, 8'h7A, 8'hFF};
   // a released bus shows a value that moves every cycle
   wire logic [7:0] io_in = !io_oe_n ? io_out : (m_drive ? m_dout : float_v);
   wire logic       op_done_flag = !busy_pull;
   always #12.5 core_clk = ~core_clk;
   always @(posedge core_clk) float_v <= float_v + 8'h35;
   nand_host nand_host_inst (.core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins(pins), .io_out(io_out),
      .io_oe_n(io_oe_n), .io_in(io_in), .op_done_flag(op_done_flag));
   flash_model flash_model_inst (.pins(pins), .bus(io_out), .dout(m_dout), .drive(m_drive),
      .busy_pull(busy_pull), .last_cmd(last_cmd), .addr_bytes(addr_bytes), .standby(standby));
   // bus tasks end 1 ns past the edge so no strobe is set twice in one step
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      #1;
   endtask
   task automatic rd(input logic [4:0] a, output logic [31:0] d);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   task automatic chk(input string what, input logic [39:0] seen, input logic [39:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // polls one status bit under a bound; running out ends the run
   task automatic wait_st(input int b, input logic val);
      logic [31:0] s;
      for (int i = 0; i < 300; i++) begin
         rd(nand_host_pkg::OFS_STATUS, s);
         if (s[b] === val) return;
      end
      mismatches++;
      report_and_stop();
   endtask
   initial begin
      repeat (3) @(posedge core_clk);
      rst <= 1'b0;
      repeat (6) @(posedge core_clk);
      #1;
      rd(nand_host_pkg::OFS_CTRL, v);
      chk("ctrl reset", v, 40'h0);
      rd(nand_host_pkg::OFS_STATUS, v);
      chk("status reset", v, 40'h2);
      chk("pins reset", pins, nand_host_pkg::PINS_RST);
      wr(nand_host_pkg::OFS_CMD, 32'h90);
      rd(nand_host_pkg::OFS_STATUS, v);
      chk("deselected refusal", v[2], 40'h1);
      rd(5'h1E, v);
      chk("unmapped", v, 40'h0);
      wr(nand_host_pkg::OFS_STATUS, 32'h0);
      wr(nand_host_pkg::OFS_CTRL, 32'h3);
      // one cycle for chip select to fall before the first pin order
      rd(nand_host_pkg::OFS_CTRL, v);
      chk("ctrl set", v, 40'h3);
      $display("test reset done");
      foreach (CODES[i]) begin
         wr(nand_host_pkg::OFS_CMD, {24'h0, CODES[i]});
         wait_st(nand_host_pkg::ST_BUSY, 1'b0);
         wait_st(nand_host_pkg::ST_READY, 1'b1);
         chk("command code", last_cmd, CODES[i]);
      end
      rd(nand_host_pkg::OFS_STATUS, v);
      chk("commands taken", v[2], 40'h0);
      $display("test commands done");
      wr(nand_host_pkg::OFS_COL, 32'h107F);
      wr(nand_host_pkg::OFS_ROW, 32'h1ABCD);
      wr(nand_host_pkg::OFS_ADDR, 32'h2);
      wait_st(nand_host_pkg::ST_BUSY, 1'b0);
      chk("address bytes", addr_bytes, 40'h01ABCD107F);
      for (int k = 0; k < 2; k++) begin
         wr(nand_host_pkg::OFS_FETCH, 32'h0);
         wait_st(nand_host_pkg::ST_BUSY, 1'b0);
         rd(nand_host_pkg::OFS_DATA, v);
         chk("fetched byte", v[7:0], (k == 0) ? 40'h25 : 40'hDA);
      end
      wr(nand_host_pkg::OFS_COL, 32'h1080);
      wr(nand_host_pkg::OFS_ADDR, 32'h0);
      rd(nand_host_pkg::OFS_STATUS, v);
      chk("column range", v[2], 40'h1);
      $display("test address and fetch done");
      wr(nand_host_pkg::OFS_STATUS, 32'h0);
      wr(nand_host_pkg::OFS_CMD, 32'h30);
      wait_st(nand_host_pkg::ST_BUSY, 1'b0);
      rd(nand_host_pkg::OFS_STATUS, v);
      chk("busy seen", v[1], 40'h0);
      wr(nand_host_pkg::OFS_CMD, 32'h90);
      rd(nand_host_pkg::OFS_STATUS, v);
      chk("busy refusal", v[2], 40'h1);
      wr(nand_host_pkg::OFS_STATUS, 32'h0);
      wr(nand_host_pkg::OFS_FETCH, 32'h0);
      rd(nand_host_pkg::OFS_STATUS, v);
      chk("busy fetch refusal", v[2], 40'h1);
      wr(nand_host_pkg::OFS_STATUS, 32'h0);
      wr(nand_host_pkg::OFS_CMD, 32'h70);
      wait_st(nand_host_pkg::ST_BUSY, 1'b0);
      chk("status while busy", last_cmd, 40'h70);
      wait_st(nand_host_pkg::ST_READY, 1'b1);
      $display("test busy done");
      wr(nand_host_pkg::OFS_CTRL, 32'h1);
      wr(nand_host_pkg::OFS_DATA, 32'hAA);
      chk("write protect pin", pins.wp_n, 40'h0);
      rd(nand_host_pkg::OFS_STATUS, v);
      chk("protected data in", v[2], 40'h1);
      $display("test write protect done");
      wr(nand_host_pkg::OFS_CTRL, 32'h0);
      rd(nand_host_pkg::OFS_CTRL, v);
      chk("ctrl cleared", v, 40'h0);
      chk("standby entered", standby, 40'h1);
      $display("test standby done");
      report_and_stop();
   end
endmodule
`default_nettype wire
